// ==== sqb_ctrl_model.sv ====
// Purpose: Controller side of the SDRAM pins.
// Assumes: Every call starts 1 ns after a rising edge.
// Notes:   Runs are far shorter than a refresh interval or row-active limit.
`timescale 1ns/10ps

module sqb_ctrl_model (
    // Clock
    input  wire logic         i_clk,
    // Pins toward the memory
    output logic              o_cke,
    output sqb_pkg::sqb_cmd_s o_cmd,
    output logic [1:0]        o_bank_sel,
    output logic [10:0]       o_addr_lines,
    output logic [3:0]        o_byte_mask,
    output logic [31:0]       o_data_lines
);
    localparam int ACT_GAP = 1;

    initial begin
        o_cke        = 1'b1;
        o_cmd        = 4'hf;
        o_bank_sel   = 2'h0;
        o_addr_lines = 11'h0;
        o_byte_mask  = 4'h0;
        o_data_lines = 32'h0;
    end

    // Rows are closed within a few cycles, refresh never falls due
    task automatic step(input logic [3:0] c, input logic [1:0] b, input logic [10:0] a,
                        input logic [3:0] m, input logic wd, input logic [31:0] d);
        o_cmd        = c;
        o_bank_sel   = b;
        o_addr_lines = a;
        o_byte_mask  = m;
        // Released lines toggle so stale data never looks valid
        o_data_lines = wd ? d : ~o_data_lines;
        @(posedge i_clk);
        #1;
    endtask : step

    task automatic open_row(input logic [1:0] b, input logic [10:0] row);
        step(4'h3, b, row, 4'h0, 1'b0, 32'h0);
        repeat (ACT_GAP) step(4'h7, b, 11'h0, 4'h0, 1'b0, 32'h0);
    endtask : open_row

    task automatic set_mode(input logic [2:0] bl, input logic il, input logic [2:0] cl,
                            input logic sw);
        step(4'h0, 2'h0, {1'b0, sw, 2'h0, cl, il, bl}, 4'h0, 1'b0, 32'h0);
    endtask : set_mode
endmodule : sqb_ctrl_model

// ==== sqb_pkg.sv ====
// Purpose: Shared constants and types of the quad-bank SDRAM command interface.
// Assumes: Mode word fields sit on the low address lines at the positions below.
// Notes:   Each mode field position and the mode, enable-history and bank reset values are named here once.
package sqb_pkg;

    // Mode word field positions on the address lines
    localparam int SQB_MODE_BL_LSB  = 0;
    localparam int SQB_MODE_BL_MSB  = 2;
    localparam int SQB_MODE_BT_BIT  = 3;
    localparam int SQB_MODE_CL_LSB  = 4;
    localparam int SQB_MODE_CL_MSB  = 6;
    localparam int SQB_MODE_WBS_BIT = 9;

    // Burst length codes
    localparam logic [2:0] SQB_BL_1    = 3'h0;
    localparam logic [2:0] SQB_BL_2    = 3'h1;
    localparam logic [2:0] SQB_BL_4    = 3'h2;
    localparam logic [2:0] SQB_BL_8    = 3'h3;
    localparam logic [2:0] SQB_BL_FULL = 3'h7;

    // Column latency codes
    localparam logic [2:0] SQB_CL_2 = 3'h2;
    localparam logic [2:0] SQB_CL_3 = 3'h3;

    // Mode reset values
    localparam logic [2:0] SQB_MODE_BL_RST  = SQB_BL_1;
    localparam logic       SQB_MODE_BT_RST  = 1'h0;
    localparam logic [2:0] SQB_MODE_CL_RST  = SQB_CL_2;
    localparam logic       SQB_MODE_WBS_RST = 1'h0;

    // Other reset values
    localparam logic       SQB_CKE_PREV_RST = 1'h0;
    localparam logic [3:0] SQB_BANK_IDLE    = 4'h0;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sqb_cmd_s;

    typedef struct packed {
        logic [2:0] bl;
        logic       interleave;
        logic [2:0] cl;
        logic       single_wr;
    } sqb_mode_s;

    typedef enum logic [7:0] {
        SQB_C_NOP = 8'h01,
        SQB_C_ACT = 8'h02,
        SQB_C_PRE = 8'h04,
        SQB_C_RD  = 8'h08,
        SQB_C_WR  = 8'h10,
        SQB_C_MRS = 8'h20,
        SQB_C_REF = 8'h40,
        SQB_C_BST = 8'h80
    } sqb_cmd_e;

    typedef enum logic [2:0] {
        SQB_PWR_RUN = 3'h1,
        SQB_PWR_PD  = 3'h2,
        SQB_PWR_SR  = 3'h4
    } sqb_pwr_e;

endpackage : sqb_pkg

// ==== sqb_sdram_core.sv ====
// Purpose: Memory-side command decoder, bank state, burst engine and data path
//          of a four-bank 32-bit synchronous DRAM.
// Assumes: All inputs synchronous to i_clk; controller keeps its own timing.
// Notes:   Refresh is accepted but has no storage effect; cells never decay.
`timescale 1ns/10ps

module sqb_sdram_core #(
    parameter int ROW_W  = 11,
    parameter int COL_W  = 8,
    parameter int DATA_W = 32
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    // Command pins
    input  wire logic                  i_cke,
    input  wire sqb_pkg::sqb_cmd_s     i_cmd,
    input  wire logic [1:0]            i_bank_sel,
    input  wire logic [ROW_W-1:0]      i_addr_lines,
    input  wire logic [DATA_W/8-1:0]   i_byte_mask,
    // Data lines
    input  wire logic [DATA_W-1:0]     i_data_lines,
    output logic      [DATA_W-1:0]     o_data_lines,
    output logic      [DATA_W/8-1:0]   o_data_oe_n,
    // Status
    output logic      [3:0]            o_bank_open,
    output logic                       o_power_down,
    output logic                       o_self_refresh,
    output logic                       o_burst_busy,
    output logic                       o_clk_held
);

    localparam int NB    = DATA_W / 8;
    localparam int IDX_W = 2 + ROW_W + COL_W;

    // Storage: four banks of rows by columns
    logic [DATA_W-1:0]      mem [0:(1<<IDX_W)-1];

    logic                   cke_prev_r;
    sqb_pkg::sqb_pwr_e      pwr_r;
    sqb_pkg::sqb_mode_s     mode_r;
    logic [3:0]             bank_open_r;
    logic [ROW_W-1:0]       open_row_r [0:3];

    logic                   b_act_r;
    logic                   b_wr_r;
    logic                   b_ap_r;
    logic                   b_full_r;
    logic                   b_inter_r;
    logic [1:0]             b_bank_r;
    logic [ROW_W-1:0]       b_row_r;
    logic [COL_W-1:0]       b_base_r;
    logic [COL_W-1:0]       b_cnt_r;
    logic [COL_W:0]         b_len_r;

    logic                   rd_v0_r;
    logic                   rd_v1_r;
    logic [DATA_W-1:0]      rd_d0_r;
    logic [DATA_W-1:0]      rd_d1_r;
    logic [NB-1:0]          mask_d1_r;
    logic [DATA_W-1:0]      out_data_r;
    logic [NB-1:0]          out_oe_n_r;
    logic                   held_r;

    logic                   en;
    sqb_pkg::sqb_cmd_e      cmd;
    logic                   new_rw;
    logic                   stop;
    logic                   single;
    logic                   acc_v;
    logic                   acc_wr;
    logic                   acc_ap;
    logic                   acc_full;
    logic                   acc_inter;
    logic [1:0]             acc_bank;
    logic [ROW_W-1:0]       acc_row;
    logic [COL_W-1:0]       acc_base;
    logic [COL_W-1:0]       acc_cnt;
    logic [COL_W:0]         acc_len;
    logic [COL_W:0]         len_m1;
    logic [COL_W-1:0]       wrap;
    logic [COL_W-1:0]       col;
    logic [IDX_W-1:0]       idx;
    logic                   last;
    logic                   sel_v;
    logic [DATA_W-1:0]      sel_d;
    logic [DATA_W-1:0]      keep;

    function automatic logic [COL_W:0] bl_len(input logic [2:0] code);
        logic [COL_W:0] n;
        n = (COL_W+1)'(1);
        case (code)
            sqb_pkg::SQB_BL_2: n = (COL_W+1)'(2);
            sqb_pkg::SQB_BL_4: n = (COL_W+1)'(4);
            sqb_pkg::SQB_BL_8: n = (COL_W+1)'(8);
            default:           n = (COL_W+1)'(1);
        endcase
        return n;
    endfunction : bl_len

    // Internal clock runs only when enable was high last edge and not in low power
    assign en = cke_prev_r && (pwr_r == sqb_pkg::SQB_PWR_RUN);

    // Command decode
    always_comb begin
        cmd = sqb_pkg::SQB_C_NOP;
        if (!i_cmd.cs_n) begin
            unique case ({i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n})
                3'h0: cmd = sqb_pkg::SQB_C_MRS;
                3'h1: cmd = sqb_pkg::SQB_C_REF;
                3'h2: cmd = sqb_pkg::SQB_C_PRE;
                3'h3: cmd = sqb_pkg::SQB_C_ACT;
                3'h4: cmd = sqb_pkg::SQB_C_WR;
                3'h5: cmd = sqb_pkg::SQB_C_RD;
                3'h6: cmd = sqb_pkg::SQB_C_BST;
                3'h7: cmd = sqb_pkg::SQB_C_NOP;
            endcase
        end
    end

    // Access selection: a new column command or the next beat of a burst
    always_comb begin
        new_rw = en && (cmd == sqb_pkg::SQB_C_RD || cmd == sqb_pkg::SQB_C_WR)
                 && bank_open_r[i_bank_sel];
        stop   = en && (cmd == sqb_pkg::SQB_C_BST
                 || (cmd == sqb_pkg::SQB_C_PRE
                     && (i_addr_lines[ROW_W-1] || i_bank_sel == b_bank_r)));
        single    = (cmd == sqb_pkg::SQB_C_WR) && mode_r.single_wr;
        acc_v     = 1'b0;
        acc_wr    = b_wr_r;
        acc_ap    = b_ap_r;
        acc_full  = b_full_r;
        acc_inter = b_inter_r;
        acc_bank  = b_bank_r;
        acc_row   = b_row_r;
        acc_base  = b_base_r;
        acc_cnt   = b_cnt_r;
        acc_len   = b_len_r;
        if (new_rw) begin
            acc_v     = 1'b1;
            acc_wr    = (cmd == sqb_pkg::SQB_C_WR);
            acc_ap    = i_addr_lines[ROW_W-1];
            acc_full  = (mode_r.bl == sqb_pkg::SQB_BL_FULL) && !single;
            acc_inter = mode_r.interleave;
            acc_bank  = i_bank_sel;
            acc_row   = open_row_r[i_bank_sel];
            acc_base  = i_addr_lines[COL_W-1:0];
            acc_cnt   = '0;
            acc_len   = single ? (COL_W+1)'(1) : bl_len(mode_r.bl);
        end else if (en && b_act_r && !stop) begin
            acc_v = 1'b1;
        end
    end

    // Burst address: wrap within the burst, linear or interleaved order
    always_comb begin
        len_m1 = acc_len - (COL_W+1)'(1);
        wrap   = acc_full ? '1 : len_m1[COL_W-1:0];
        if (acc_inter && !acc_full) begin
            col = (acc_base & ~wrap) | ((acc_base ^ acc_cnt) & wrap);
        end else begin
            col = (acc_base & ~wrap) | ((acc_base + acc_cnt) & wrap);
        end
        idx  = {acc_bank, acc_row, col};
        last = acc_v && !acc_full && (({1'b0, acc_cnt} + (COL_W+1)'(1)) == acc_len);
    end

    // Enable history; sampled every edge so suspension starts one cycle late
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cke_prev_r <= sqb_pkg::SQB_CKE_PREV_RST;
            held_r     <= 1'b1;
        end else begin
            cke_prev_r <= i_cke;
            held_r     <= !i_cke;
        end
    end

    // Power state; a burst in flight turns entry into plain suspension
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pwr_r <= sqb_pkg::SQB_PWR_RUN;
        end else begin
            unique case (pwr_r)
                sqb_pkg::SQB_PWR_RUN: begin
                    if (cke_prev_r && !i_cke && bank_open_r == sqb_pkg::SQB_BANK_IDLE
                        && !b_act_r) begin
                        pwr_r <= (cmd == sqb_pkg::SQB_C_REF) ? sqb_pkg::SQB_PWR_SR
                                                             : sqb_pkg::SQB_PWR_PD;
                    end
                end
                sqb_pkg::SQB_PWR_PD,
                sqb_pkg::SQB_PWR_SR: begin
                    // Only enable is watched here; all other pins are dropped
                    if (i_cke) begin
                        pwr_r <= sqb_pkg::SQB_PWR_RUN;
                    end
                end
                default: pwr_r <= sqb_pkg::SQB_PWR_RUN;
            endcase
        end
    end

    // Mode settings; loaded only when all banks are idle
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mode_r.bl         <= sqb_pkg::SQB_MODE_BL_RST;
            mode_r.interleave <= sqb_pkg::SQB_MODE_BT_RST;
            mode_r.cl         <= sqb_pkg::SQB_MODE_CL_RST;
            mode_r.single_wr  <= sqb_pkg::SQB_MODE_WBS_RST;
        end else if (en && cmd == sqb_pkg::SQB_C_MRS
                     && bank_open_r == sqb_pkg::SQB_BANK_IDLE && !b_act_r) begin
            mode_r.bl         <= i_addr_lines[sqb_pkg::SQB_MODE_BL_MSB:
                                              sqb_pkg::SQB_MODE_BL_LSB];
            mode_r.interleave <= i_addr_lines[sqb_pkg::SQB_MODE_BT_BIT];
            mode_r.cl         <= i_addr_lines[sqb_pkg::SQB_MODE_CL_MSB:
                                              sqb_pkg::SQB_MODE_CL_LSB];
            mode_r.single_wr  <= i_addr_lines[sqb_pkg::SQB_MODE_WBS_BIT];
        end
    end

    // Bank open state and open row
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            bank_open_r <= sqb_pkg::SQB_BANK_IDLE;
            for (int b = 0; b < 4; b++) begin
                open_row_r[b] <= '0;
            end
        end else if (en) begin
            if (cmd == sqb_pkg::SQB_C_ACT && !bank_open_r[i_bank_sel]) begin
                bank_open_r[i_bank_sel] <= 1'b1;
                open_row_r[i_bank_sel]  <= i_addr_lines;
            end
            if (last && acc_ap) begin
                bank_open_r[acc_bank] <= 1'b0;
            end
            if (cmd == sqb_pkg::SQB_C_PRE) begin
                if (i_addr_lines[ROW_W-1]) begin
                    bank_open_r <= sqb_pkg::SQB_BANK_IDLE;
                end else begin
                    bank_open_r[i_bank_sel] <= 1'b0;
                end
            end
        end
    end

    // Burst counter; a new column command cuts off the running burst
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            b_act_r   <= 1'b0;
            b_wr_r    <= 1'b0;
            b_ap_r    <= 1'b0;
            b_full_r  <= 1'b0;
            b_inter_r <= 1'b0;
            b_bank_r  <= '0;
            b_row_r   <= '0;
            b_base_r  <= '0;
            b_cnt_r   <= '0;
            b_len_r   <= '0;
        end else if (new_rw) begin
            b_act_r   <= !last;
            b_wr_r    <= acc_wr;
            b_ap_r    <= acc_ap;
            b_full_r  <= acc_full;
            b_inter_r <= acc_inter;
            b_bank_r  <= acc_bank;
            b_row_r   <= acc_row;
            b_base_r  <= acc_base;
            b_cnt_r   <= COL_W'(1);
            b_len_r   <= acc_len;
        end else if (acc_v) begin
            b_act_r <= !last;
            b_cnt_r <= b_cnt_r + COL_W'(1);
        end else if (stop) begin
            b_act_r <= 1'b0;
        end
    end

    // Storage port: write with byte masks, read into the latency pipe
    always_ff @(posedge i_clk) begin
        if (en && acc_v && acc_wr) begin
            for (int b = 0; b < NB; b++) begin
                if (!i_byte_mask[b]) begin
                    mem[idx][b*8 +: 8] <= i_data_lines[b*8 +: 8];
                end
            end
        end
        if (en) begin
            rd_d0_r <= mem[idx];
            rd_d1_r <= rd_d0_r;
        end
    end

    // Read latency pipe and mask delay; everything holds while suspended
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rd_v0_r   <= 1'b0;
            rd_v1_r   <= 1'b0;
            mask_d1_r <= '1;
        end else if (en) begin
            rd_v0_r   <= acc_v && !acc_wr;
            rd_v1_r   <= rd_v0_r;
            mask_d1_r <= i_byte_mask;
        end
    end

    always_comb begin
        sel_v = (mode_r.cl == sqb_pkg::SQB_CL_3) ? rd_v1_r : rd_v0_r;
        sel_d = (mode_r.cl == sqb_pkg::SQB_CL_3) ? rd_d1_r : rd_d0_r;
        keep  = '0;
        for (int b = 0; b < NB; b++) begin
            keep[b*8 +: 8] = {8{sel_v && !mask_d1_r[b]}};
        end
    end

    // Output registers; a masked byte also releases its driver
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            out_data_r <= '0;
            out_oe_n_r <= '1;
        end else if (en) begin
            out_data_r <= sel_d & keep;
            for (int b = 0; b < NB; b++) begin
                out_oe_n_r[b] <= !keep[b*8];
            end
        end
    end

    assign o_data_lines   = out_data_r;
    assign o_data_oe_n    = out_oe_n_r;
    assign o_bank_open    = bank_open_r;
    // One-hot state bits come straight from the state flops
    assign o_power_down   = pwr_r[1];
    assign o_self_refresh = pwr_r[2];
    assign o_burst_busy   = b_act_r;
    assign o_clk_held     = held_r;

endmodule : sqb_sdram_core

// ==== sqb_sdram_core_monitor.sv ====
// Purpose: Concurrent checks on the pins of the SDRAM core.
// Assumes: One clock, synchronous active-low reset.
// Notes:   The held flag marks edges where nothing may be decoded.
`timescale 1ns/10ps

module sqb_sdram_core_monitor #(
    parameter int ROW_W  = 11,
    parameter int COL_W  = 8,
    parameter int DATA_W = 32
) (
    // Inputs of the core
    input wire logic                i_clk,
    input wire logic                i_rstn,
    input wire logic                i_cke,
    input wire sqb_pkg::sqb_cmd_s   i_cmd,
    input wire logic [1:0]          i_bank_sel,
    input wire logic [ROW_W-1:0]    i_addr_lines,
    input wire logic [DATA_W/8-1:0] i_byte_mask,
    input wire logic [DATA_W-1:0]   i_data_lines,
    // Outputs of the core
    input wire logic [DATA_W-1:0]   o_data_lines,
    input wire logic [DATA_W/8-1:0] o_data_oe_n,
    input wire logic [3:0]          o_bank_open,
    input wire logic                o_power_down,
    input wire logic                o_self_refresh,
    input wire logic                o_burst_busy,
    input wire logic                o_clk_held
);
    logic [2:0] code;
    logic       en, act, pre, rd, wr, ref_c;
    assign code  = {i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
    // Decode edge: clock enabled last edge and not asleep
    assign en    = !o_clk_held && !o_power_down && !o_self_refresh && !i_cmd.cs_n;
    assign act   = en && code == 3'h3;
    assign pre   = en && code == 3'h2;
    assign rd    = en && code == 3'h5;
    assign wr    = en && code == 3'h4;
    assign ref_c = !i_cmd.cs_n && code == 3'h1;

    function automatic logic [DATA_W-1:0] mx(input logic [DATA_W/8-1:0] m);
        logic [DATA_W-1:0] r;
        for (int b = 0; b < DATA_W/8; b++) r[8*b +: 8] = {8{m[b]}};
        return r;
    endfunction : mx

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_pre_all;
        pre && i_addr_lines[10];
    endsequence
    // Beat zero of a read must surface whatever the latency
    sequence s_rd_clean;
        (rd && o_bank_open[i_bank_sel] && i_cke && i_byte_mask == '0)
            ##1 (i_cke && i_byte_mask == '0)[*2];
    endsequence

    a_held_flag: assert property (1'b1 |=> o_clk_held == !$past(i_cke))
        else $error("held flag does not follow clock enable");
    a_hold_freeze: assert property (o_clk_held |=> $stable(o_data_lines)
        && $stable(o_data_oe_n) && $stable(o_bank_open))
        else $error("outputs moved while clock held");
    a_mask_blank: assert property (!o_clk_held && !o_power_down && !o_self_refresh
        ##1 !o_clk_held |=> (o_data_oe_n & $past(i_byte_mask, 2)) == $past(i_byte_mask, 2)
        && (o_data_lines & mx($past(i_byte_mask, 2))) == '0)
        else $error("masked byte not blanked two clocks later");
    a_lp_entry: assert property (!o_clk_held && !i_cke && o_bank_open == 4'h0
        && !o_burst_busy && !o_power_down && !o_self_refresh
        |=> o_self_refresh == $past(ref_c) && o_power_down == !$past(ref_c))
        else $error("low-power entry wrong");
    a_lp_ignore: assert property ((o_power_down || o_self_refresh)
        |=> $stable(o_bank_open) && o_data_oe_n == '1)
        else $error("activity during low power");
    a_act_opens: assert property (act && !o_bank_open[i_bank_sel]
        |=> o_bank_open[$past(i_bank_sel)])
        else $error("activate did not open bank");
    a_pre_one: assert property (pre && !i_addr_lines[10]
        |=> !o_bank_open[$past(i_bank_sel)])
        else $error("precharge left bank open");
    a_pre_all: assert property (s_pre_all |=> o_bank_open == 4'h0)
        else $error("precharge all left a bank open");
    a_cs_ignore: assert property (i_cmd.cs_n && !o_burst_busy |=> $stable(o_bank_open))
        else $error("deselected command acted");
    a_closed_refused: assert property ((rd || wr) && !o_bank_open[i_bank_sel]
        && !o_burst_busy |=> !o_burst_busy)
        else $error("access to closed bank started a burst");
    a_read_drives: assert property (s_rd_clean |-> ##[0:1] o_data_oe_n == '0)
        else $error("read produced no output word");
endmodule : sqb_sdram_core_monitor

bind sqb_sdram_core sqb_sdram_core_monitor #(.ROW_W(ROW_W), .COL_W(COL_W), .DATA_W(DATA_W))
    u_mon (.i_clk(i_clk), .i_rstn(i_rstn), .i_cke(i_cke), .i_cmd(i_cmd),
    .i_bank_sel(i_bank_sel), .i_addr_lines(i_addr_lines), .i_byte_mask(i_byte_mask),
    .i_data_lines(i_data_lines), .o_data_lines(o_data_lines), .o_data_oe_n(o_data_oe_n),
    .o_bank_open(o_bank_open), .o_power_down(o_power_down),
    .o_self_refresh(o_self_refresh), .o_burst_busy(o_burst_busy), .o_clk_held(o_clk_held));

// ==== tb_sqb_sdram_core.sv ====
// Purpose: Self-checking bench of the SDRAM core.
// Assumes: Controller model drives pins 1 ns after each rising edge.
// Notes:   A shadow array predicts every read word.
`timescale 1ns/10ps

`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", nm, (exp), (got)); end end

module tb_sqb_sdram_core;
    logic              i_clk, i_rstn, cke, pd, sr, busy, held;
    sqb_pkg::sqb_cmd_s cmd;
    logic [1:0]        bank_sel;
    logic [10:0]       addr;
    logic [3:0]        mask, oe_n, bank_open;
    logic [31:0]       wdata, rdata;
    logic [31:0]       mem [int];
    int                error_cnt = 0, n_compared = 0, cycles = 0, wseq = 0, bl;

    sqb_sdram_core DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_cke(cke), .i_cmd(cmd),
        .i_bank_sel(bank_sel), .i_addr_lines(addr), .i_byte_mask(mask),
        .i_data_lines(wdata), .o_data_lines(rdata), .o_data_oe_n(oe_n),
        .o_bank_open(bank_open), .o_power_down(pd), .o_self_refresh(sr),
        .o_burst_busy(busy), .o_clk_held(held));
    sqb_ctrl_model ctl (.i_clk(i_clk), .o_cke(cke), .o_cmd(cmd), .o_bank_sel(bank_sel),
        .o_addr_lines(addr), .o_byte_mask(mask), .o_data_lines(wdata));

    initial i_clk = 1'b0;
    always #50 i_clk = ~i_clk;

    function automatic logic [31:0] mx(input logic [3:0] m);
        return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    endfunction : mx

    // Column of beat j inside the aligned burst block
    function automatic logic [7:0] bcol(input logic [7:0] c, input int j, input int n,
                                        input logic il);
        logic [7:0] k;
        k = 8'(n - 1);
        return il ? (c ^ 8'(j)) : ((c & ~k) | ((c + 8'(j)) & k));
    endfunction : bcol

    task automatic wr(input logic [1:0] b, input logic [10:0] row, input logic [7:0] c,
                      input int n, input int blk, input logic il, input logic [31:0] mp,
                      input logic ap, input logic st);
        logic [7:0]  cj;
        logic [31:0] d;
        int          key;
        for (int j = 0; j < n; j++) begin
            cj  = bcol(c, j, blk, il);
            d   = {b, row, cj, 3'h0, wseq[7:0]};
            key = {b, row, cj};
            wseq++;
            if (!mem.exists(key)) mem[key] = 'x;
            mem[key] = (mem[key] & mx(mp[4*j +: 4])) | (d & ~mx(mp[4*j +: 4]));
            ctl.step(j == 0 ? 4'h4 : 4'h7, b, j == 0 ? {ap, 2'h0, c} : 11'h0,
                     mp[4*j +: 4], 1'b1, d);
        end
        if (st) ctl.step(4'h6, 2'h0, 11'h0, 4'h0, 1'b0, 32'h0);
    endtask : wr

    task automatic rd(input logic [1:0] b, input logic [10:0] row, input logic [7:0] c,
                      input int n, input int blk, input logic il, input int cl,
                      input logic [31:0] mp, input logic ap, input logic st);
        logic [3:0]  m, cc;
        logic [31:0] e;
        int          i, jb, key;
        for (int k = 0; k <= n + cl - 2; k++) begin
            i  = k - (cl - 2);
            m  = (i >= 0 && i < n) ? mp[4*i +: 4] : 4'h0;
            cc = (k == 0) ? 4'h5 : ((st && k == n) ? 4'h6 : 4'h7);
            ctl.step(cc, b, (k == 0) ? {ap, 2'h0, c} : 11'h0, m, 1'b0, 32'h0);
            jb = k - (cl - 1);
            if (jb >= 0) begin
                key = {b, row, bcol(c, jb, blk, il)};
                m   = mp[4*jb +: 4];
                e   = mem[key] & ~mx(m);
                `CHK("read word", e, rdata);
                `CHK("read oe_n", m, oe_n);
            end
        end
    endtask : rd

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // Whole run needs under a thousand cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        i_rstn = 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        `CHK("reset state", 12'hf01, {oe_n, bank_open, pd, sr, busy, held});
        i_rstn = 1'b1;
        repeat (2) ctl.step(4'h7, 2'h0, 11'h0, 4'h0, 1'b0, 32'h0);
        ctl.set_mode(sqb_pkg::SQB_BL_4, 1'b0, sqb_pkg::SQB_CL_2, 1'b0);
        ctl.open_row(2'h1, 11'h003);
        `CHK("bank open", 4'h2, bank_open);
        wr(2'h1, 11'h3, 8'h04, 4, 4, 1'b0, 32'h0, 1'b0, 1'b0);
        wr(2'h1, 11'h3, 8'h04, 4, 4, 1'b0, 32'h1248, 1'b0, 1'b0);
        rd(2'h1, 11'h3, 8'h06, 4, 4, 1'b0, 2, 32'h8421, 1'b0, 1'b0);
        ctl.step(4'hb, 2'h2, 11'h0, 4'h0, 1'b0, 32'h0);
        ctl.step(4'hd, 2'h1, 11'h0, 4'h0, 1'b0, 32'h0);
        ctl.step(4'h5, 2'h2, 11'h0, 4'h0, 1'b0, 32'h0);
        repeat (3) ctl.step(4'h7, 2'h0, 11'h0, 4'h0, 1'b0, 32'h0);
        `CHK("refused", 9'h05e, {bank_open, oe_n, busy});
        // Suspend mid-burst: beat zero lands, then two frozen edges
        ctl.step(4'h5, 2'h1, 11'h004, 4'h0, 1'b0, 32'h0);
        ctl.o_cke = 1'b0;
        repeat (2) ctl.step(4'h7, 2'h0, 11'h0, 4'h0, 1'b0, 32'h0);
        ctl.o_cke = 1'b1;
        ctl.step(4'h7, 2'h0, 11'h0, 4'h0, 1'b0, 32'h0);
        `CHK("suspended", {mem[{2'h1, 11'h3, 8'h04}], 1'b1}, {rdata, busy});
        ctl.step(4'h7, 2'h0, 11'h0, 4'h0, 1'b0, 32'h0);
        `CHK("resumed", mem[{2'h1, 11'h3, 8'h05}], rdata);
        repeat (3) ctl.step(4'h7, 2'h0, 11'h0, 4'h0, 1'b0, 32'h0);
        ctl.open_row(2'h2, 11'h7ff);
        ctl.open_row(2'h3, 11'h000);
        ctl.step(4'h2, 2'h2, 11'h0, 4'h0, 1'b0, 32'h0);
        `CHK("bank close", 4'ha, bank_open);
        ctl.step(4'h2, 2'h0, 11'h400, 4'h0, 1'b0, 32'h0);
        `CHK("close all", 4'h0, bank_open);
        for (int q = 0; q < 16; q++) begin
            bl = 1 << q[1:0];
            ctl.set_mode({1'b0, q[1:0]}, q[2], q[3] ? sqb_pkg::SQB_CL_3 : sqb_pkg::SQB_CL_2,
                         1'b0);
            ctl.open_row(2'h0, 11'h7);
            wr(2'h0, 11'h7, 8'h35, bl, bl, q[2], 32'h0, 1'b0, 1'b0);
            rd(2'h0, 11'h7, 8'h34 | 8'(bl == 1), bl, bl, q[2], q[3] ? 3 : 2, 32'h0, 1'b1,
               1'b0);
            `CHK("auto close", 4'h0, bank_open);
        end
        ctl.set_mode(sqb_pkg::SQB_BL_FULL, 1'b0, sqb_pkg::SQB_CL_2, 1'b0);
        ctl.open_row(2'h3, 11'h5);
        wr(2'h3, 11'h5, 8'hfe, 3, 256, 1'b0, 32'h0, 1'b0, 1'b1);
        rd(2'h3, 11'h5, 8'hfe, 3, 256, 1'b0, 2, 32'h0, 1'b0, 1'b1);
        `CHK("stopped", 1'b0, busy);
        ctl.step(4'h2, 2'h0, 11'h400, 4'h0, 1'b0, 32'h0);
        ctl.set_mode(sqb_pkg::SQB_BL_4, 1'b0, sqb_pkg::SQB_CL_2, 1'b1);
        ctl.open_row(2'h0, 11'h1);
        wr(2'h0, 11'h1, 8'h10, 1, 1, 1'b0, 32'h0, 1'b0, 1'b0);
        `CHK("single write", 1'b0, busy);
        ctl.step(4'h2, 2'h0, 11'h400, 4'h0, 1'b0, 32'h0);
        for (int e = 0; e < 2; e++) begin
            ctl.o_cke = 1'b0;
            ctl.step(e ? 4'h1 : 4'h7, 2'h0, 11'h0, 4'h0, 1'b0, 32'h0);
            ctl.step(4'h3, 2'h0, 11'h1, 4'h0, 1'b0, 32'h0);
            `CHK("low power", {e == 1, e == 0, 4'h0}, {sr, pd, bank_open});
            ctl.o_cke = 1'b1;
            repeat (2) ctl.step(4'h7, 2'h0, 11'h0, 4'h0, 1'b0, 32'h0);
            `CHK("woken", 2'b00, {sr, pd});
        end
        finish_test();
    end
endmodule : tb_sqb_sdram_core
